//--- src/lin_status_error_flags.sv
/*
 LIN status and error flag block with an APB register slave.
 Assumes the frame sequencer drives link_events_t synchronous to pclk,
 with pulses one cycle wide, and that bit_sample only pulses while the
 device itself transmits.
*/
`timescale 1ns/1ps

module lin_status_error_flags
    import lin_status_pkg::*;
#(
    parameter int unsigned CNT_W        = 32,
    parameter int unsigned IDLE_CYCLES  = IDLE_TIMEOUT_CYCLES,
    parameter int unsigned FRAME_CYCLES = MAX_FRAME_CYCLES,
    parameter int unsigned RESP_CYCLES  = RESPONSE_CYCLES
)(
    // Clock and reset
    input  wire  logic                           pclk,
    input  wire  logic                           presetn,
    // APB slave
    input  wire  logic                           psel,
    input  wire  logic                           penable,
    input  wire  logic                           pwrite,
    input  wire  logic [lin_status_pkg::ADDR_W-1:0] paddr,
    input  wire  logic [lin_status_pkg::DATA_W-1:0] pwdata,
    output logic       [lin_status_pkg::DATA_W-1:0] prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // Frame sequencer
    input  wire  lin_status_pkg::link_events_t   events,
    output lin_status_pkg::link_cmd_t            cmd
);
    import lin_status_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        reg_hit = (a == {2'b00, idx, 2'b00});
    endfunction : reg_hit

    apb_state_t             state;
    apb_state_t             next_state;
    logic [REG_W-1:0]       status;
    logic [ERR_W-1:0]       errors;
    logic                   in_frame;
    logic                   wake_seen;
    logic                   ack_pending;
    logic [CNT_W-1:0]       idle_cnt;
    logic [CNT_W-1:0]       frame_cnt;
    logic [CNT_W-1:0]       resp_cnt;

    // Bus decode
    wire hit_ctl  = reg_hit(paddr, CONTROL_IDX);
    wire hit_st   = reg_hit(paddr, STATUS_IDX);
    wire hit_err  = reg_hit(paddr, ERROR_IDX);
    wire hit_mode = reg_hit(paddr, MODE_IDX);
    wire mapped   = hit_ctl | hit_st | hit_err | hit_mode;
    wire request  = psel & penable;
    // Write takes effect only at the edge where pready is seen high
    wire commit   = (state == APB_ANSWER) & request & pwrite & mapped;
    wire ctl_wr   = commit & hit_ctl;
    wire mode_wr  = commit & hit_mode;

    wire slave     = ~cmd.master_mode;
    wire halt_wr   = ctl_wr & pwdata[CTL_HALT] & slave;
    wire dack_wr   = ctl_wr & pwdata[CTL_DACK] & slave;
    wire intclr_wr = ctl_wr & pwdata[CTL_INTCLR];
    wire fltclr_wr = ctl_wr & pwdata[CTL_FLTCLR];

    // Halted traffic is masked; the sync break itself always passes
    wire live         = ~cmd.halted;
    wire sync_break   = events.sync_break;
    wire frame_start  = events.frame_start & live;
    wire frame_end    = events.frame_end & live;
    wire id_rx        = events.id_received & live & slave;
    wire irq_ev       = events.irq_event & live;
    wire wake_rx      = events.wakeup_rx & live;
    wire data_byte    = events.data_byte & live;
    wire awaiting     = events.awaiting_data & live;
    wire first_byte   = events.first_byte_done & live;

    // Halt write wins over a sync break in the same cycle
    wire next_halted  = halt_wr | (cmd.halted & ~sync_break);

    // Timers
    wire idle_run  = slave & ~events.bus_activity & ~events.sleep_mode;
    wire idle_hit  = idle_run & (idle_cnt == CNT_W'(IDLE_CYCLES - 1));
    wire frame_hit = in_frame & (frame_cnt == CNT_W'(FRAME_CYCLES - 1));
    wire resp_run  = awaiting & ~data_byte;
    wire resp_hit  = resp_run & (resp_cnt == CNT_W'(RESP_CYCLES - 1));
    wire ack_late  = first_byte & ack_pending & ~dack_wr & ~halt_wr;

    wire next_in_frame = frame_start |
                         (in_frame & ~frame_end & ~sync_break & ~frame_hit);

    // Error causes; sync and parity checks exist in slave mode only
    wire              rx_live = live & slave;
    logic [ERR_W-1:0] err_set;
    always_comb
    begin
        err_set              = '0;
        err_set[ER_SYNC]     = events.sync_tolerance_fail & rx_live;
        err_set[ER_PARITY]   = events.parity_fail & rx_live;
        err_set[ER_TIMEOUT]  = (resp_hit & cmd.master_mode)
                             | (resp_hit & slave)
                             | frame_hit
                             | ack_late;
        err_set[ER_CHECKSUM] = events.checksum_fail & live;
        err_set[ER_BIT]      = events.bit_sample & live &
                               (events.bit_driven != events.bit_monitored);
    end

    // Sticky errors; a new cause beats a clear in the same cycle
    wire [ERR_W-1:0] next_errors = (errors & ~{ERR_W{fltclr_wr}})
                                 | err_set;

    // Status word
    wire next_wake_seen = wake_rx | (wake_seen & ~frame_start);
    wire next_ack_pend  = id_rx | (ack_pending & ~dack_wr & ~halt_wr &
                                   ~first_byte & ~sync_break);

    logic [REG_W-1:0] next_status;
    always_comb
    begin
        next_status            = status;
        next_status[ST_ACTIVE] = events.bus_activity;
        next_status[ST_IDLE]   = idle_run &
                                 (status[ST_IDLE] | idle_hit);
        next_status[ST_ABORT]  = (sync_break & in_frame & slave)
                               | halt_wr
                               | (status[ST_ABORT] &
                                  ~(sync_break & ~in_frame));
        next_status[ST_DREQ]   = id_rx
                               | (status[ST_DREQ] & ~dack_wr &
                                  ~halt_wr & ~sync_break);
        next_status[ST_INT]    = irq_ev
                               | (status[ST_INT] & ~intclr_wr);
        next_status[ST_FAULT]  = (|err_set)
                               | (status[ST_FAULT] & ~fltclr_wr);
        next_status[ST_WAKE]   = events.wakeup_tx & live
                               | next_wake_seen;
        next_status[ST_DONE]   = frame_end
                               | (status[ST_DONE] & ~frame_start);
    end

    // Read mux
    logic [DATA_W-1:0] read_word;
    always_comb
    begin
        read_word = '0;
        if (hit_st)
            read_word[REG_W-1:0] = status;
        else if (hit_err)
            read_word[ERR_W-1:0] = errors;
        else if (hit_mode)
            read_word[MODE_MASTER] = cmd.master_mode;
    end

    // APB phase sequencing: one wait state, answer in second access cycle
    always_comb
    begin
        next_state = APB_SETUP;
        unique case (state)
            APB_SETUP:
                if (request)
                    next_state = APB_ANSWER;
            APB_ANSWER:
                next_state = APB_SETUP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= APB_SETUP;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            state   <= next_state;
            pready  <= (next_state == APB_ANSWER);
            pslverr <= (next_state == APB_ANSWER) & ~mapped;
            prdata  <= (next_state == APB_ANSWER && !pwrite) ? read_word
                                                              : '0;
        end
    end

    // Flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status      <= REG_RESET;
            errors      <= ERR_W'(REG_RESET);
            in_frame    <= 1'b0;
            wake_seen   <= 1'b0;
            ack_pending <= 1'b0;
        end
        else
        begin
            status      <= next_status;
            errors      <= next_errors;
            in_frame    <= next_in_frame;
            wake_seen   <= next_wake_seen;
            ack_pending <= next_ack_pend;
        end
    end

    // Idle timer; saturates so the flag holds until activity, sleep mode or master mode ends it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_cnt <= '0;
        else if (!idle_run)
            idle_cnt <= '0;
        else if (!idle_hit && !status[ST_IDLE])
            idle_cnt <= idle_cnt + 1'b1;
    end

    // Frame length timer; the overrun ends the frame once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_cnt <= '0;
        else if (!in_frame || frame_start)
            frame_cnt <= '0;
        else
            frame_cnt <= frame_cnt + 1'b1;
    end

    // Response timer; restarts on every received byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            resp_cnt <= '0;
        else if (!resp_run || resp_hit)
            resp_cnt <= '0;
        else
            resp_cnt <= resp_cnt + 1'b1;
    end

    // Commands to the sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd <= '0;
        else
        begin
            cmd.halted      <= next_halted;
            cmd.data_ack    <= dack_wr;
            cmd.master_mode <= mode_wr ? pwdata[MODE_MASTER]
                                       : cmd.master_mode;
        end
    end

endmodule : lin_status_error_flags

//--- src/lin_status_pkg.sv
/*
 Shared constants, field layouts and carrier types of the LIN status and
 error flag block. Assumes a 250 MHz APB clock and a frame sequencer
 outside the block that reports bus events as single-cycle pulses.
*/
package lin_status_pkg;

    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          REG_W       = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  CONTROL_IDX = 8'h08;
    localparam logic [7:0]  STATUS_IDX  = 8'h09;
    localparam logic [7:0]  ERROR_IDX   = 8'h0a;
    localparam logic [7:0]  MODE_IDX    = 8'h0c;

    localparam logic [REG_W-1:0] REG_RESET = 8'h00;

    // link_control command bits
    localparam int CTL_HALT     = 7;
    localparam int CTL_DACK     = 4;
    localparam int CTL_INTCLR   = 3;
    localparam int CTL_FLTCLR   = 2;

    // link_mode bits
    localparam int MODE_MASTER  = 0;

    // link_status bits
    localparam int ST_ACTIVE    = 7;
    localparam int ST_IDLE      = 6;
    localparam int ST_ABORT     = 5;
    localparam int ST_DREQ      = 4;
    localparam int ST_INT       = 3;
    localparam int ST_FAULT     = 2;
    localparam int ST_WAKE      = 1;
    localparam int ST_DONE      = 0;

    // link_error_causes bits
    localparam int ERR_W        = 5;
    localparam int ER_SYNC      = 4;
    localparam int ER_PARITY    = 3;
    localparam int ER_TIMEOUT   = 2;
    localparam int ER_CHECKSUM  = 1;
    localparam int ER_BIT       = 0;

    // Timing
    localparam int unsigned CLK_HZ              = 250_000_000;
    localparam int unsigned IDLE_TIMEOUT_S      = 4;
    localparam int unsigned IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_S * CLK_HZ;
    localparam int unsigned MAX_FRAME_CYCLES    = 100_000;
    localparam int unsigned RESPONSE_CYCLES     = 50_000;

    // Events reported by the frame sequencer
    typedef struct packed {
        logic bus_activity;
        logic sleep_mode;
        logic sync_break;
        logic frame_start;
        logic frame_end;
        logic id_received;
        logic irq_event;
        logic wakeup_tx;
        logic wakeup_rx;
        logic sync_tolerance_fail;
        logic parity_fail;
        logic checksum_fail;
        logic bit_sample;
        logic bit_driven;
        logic bit_monitored;
        logic awaiting_data;
        logic data_byte;
        logic first_byte_done;
    } link_events_t;

    // Commands back to the frame sequencer
    typedef struct packed {
        logic halted;
        logic data_ack;
        logic master_mode;
    } link_cmd_t;

    typedef enum logic [0:0] {
        APB_SETUP  = 1'b0,
        APB_ANSWER = 1'b1
    } apb_state_t;

endpackage : lin_status_pkg

//--- verification/lin_status_properties.sv
/* APB timing and command pulse checks for the status and error block.
   Assumes it is bound to lin_status_error_flags. */
`timescale 1ns/1ps
module lin_status_props (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Sequencer side
    input wire lin_status_pkg::link_events_t events,
    input wire lin_status_pkg::link_cmd_t    cmd
);
    import lin_status_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_ok = pready && !pwrite;
    wire ctl = paddr == {2'b00, CONTROL_IDX, 2'b00};
    wire err = paddr == {2'b00, ERROR_IDX, 2'b00};
    wire mapped = ctl || err || paddr == {2'b00, STATUS_IDX, 2'b00}
        || paddr == {2'b00, MODE_IDX, 2'b00};
    wire ctl_rd   = rd_ok && ctl;
    wire err_rd   = rd_ok && err;
    wire wr_ok    = pready && pwrite && ctl && !cmd.master_mode;
    wire halt_wr  = wr_ok && pwdata[CTL_HALT];
    wire dack_wr  = wr_ok && pwdata[CTL_DACK];
    wire halt_end = cmd.halted && events.sync_break;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready;
    endsequence
    a_one_wait: assert property (s_setup ##1 s_access |=> pready ##1 !pready)
        else $error("access phase length wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_unmapped_err: assert property (pready |-> pslverr == !mapped)
        else $error("slave error flag mismatch");
    a_ctrl_reads_zero: assert property (ctl_rd |-> prdata == 32'h0)
        else $error("control word read not zero");
    a_err_upper_zero: assert property (err_rd |-> prdata[31:5] == '0)
        else $error("error word upper bits set");
    a_dack_pulse: assert property ($rose(cmd.data_ack) |=> !cmd.data_ack)
        else $error("data ack longer than one cycle");
    a_dack_set: assert property (dack_wr |=> cmd.data_ack)
        else $error("data ack write gave no pulse");
    a_halt_set: assert property (halt_wr |=> cmd.halted)
        else $error("halt write did not halt");
    a_halt_release: assert property (halt_end |=> !cmd.halted)
        else $error("halt kept after sync break");
endmodule : lin_status_props

bind lin_status_error_flags lin_status_props lin_status_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .cmd(cmd));

//--- verification/lin_far_node.sv
/* Behavioural frame sequencer standing in for the remote LIN nodes.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module lin_far_node (
    // Clock
    input  wire logic                   pclk,
    // Events to the block
    output lin_status_pkg::link_events_t events
);
    import lin_status_pkg::*;
    link_events_t lvl = '0;
    initial events = '0;
    task level(input link_events_t l);
        @(posedge pclk);
        lvl = l;
        events <= l;
    endtask : level
    // Levels stay up under a pulse, as on a live bus
    task pulse(input link_events_t p);
        @(posedge pclk);
        events <= lvl | p;
        @(posedge pclk);
        events <= lvl;
    endtask : pulse
endmodule : lin_far_node

//--- verification/tb.sv
/* Self-checking bench: APB master tasks plus event stimulus.
   Assumes short IDLE, FRAME and RESP counts set below. */
`timescale 1ns/1ps
module tb;
    import lin_status_pkg::*;
    localparam logic [11:0] CTL = {2'b00, CONTROL_IDX, 2'b00};
    localparam logic [11:0] STA = {2'b00, STATUS_IDX, 2'b00};
    localparam logic [11:0] ERR = {2'b00, ERROR_IDX, 2'b00};
    localparam logic [11:0] MOD = {2'b00, MODE_IDX, 2'b00};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic pready, pslverr, rerr;
    link_events_t events, err_ev [4];
    link_cmd_t cmd;
    logic [7:0] err_bit [4];
    int num_errors = 0, cmp_count = 0, cyc = 0;
    lin_status_error_flags #(.IDLE_CYCLES(20), .FRAME_CYCLES(40),
        .RESP_CYCLES(20)) lin_status_error_flags_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .cmd(cmd));
    lin_far_node far_i (.pclk(pclk), .events(events));
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            num_errors++;
            final_report();
        end
    end
    // Positions follow the link_events_t field order
    function automatic link_events_t ev(input int k);
        ev = '0;
        ev[k] = 1'b1;
    endfunction : ev
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) num_errors++;
    endtask : apb
    task automatic same(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask : same
    task automatic chk(input string nm, input logic [11:0] a,
                       input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        same(nm, e, rdata[7:0] & m);
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic clr();
        wr(CTL, 8'h04);
    endtask : clr
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        err_ev = '{ev(8), ev(7), ev(6), ev(5) | ev(4)};
        err_bit = '{8'h10, 8'h08, 8'h02, 8'h01};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("status", STA, 8'hff, 8'h00);
        chk("errors", ERR, 8'hff, 8'h00);
        chk("control", CTL, 8'hff, 8'h00);
        chk("unmapped", 12'h040, 8'hff, 8'h00);
        same("slave error", 8'h01, {7'h0, rerr});
        far_i.level(ev(17));
        chk("active", STA, 8'h80, 8'h80);
        far_i.level('0);
        wt(25);
        chk("idle", STA, 8'hc0, 8'h40);
        far_i.level(ev(17));
        chk("idle off", STA, 8'hc0, 8'h80);
        far_i.level(ev(16));
        wt(25);
        chk("sleep no idle", STA, 8'h40, 8'h00);
        far_i.level(ev(17));
        $display("test basics done");
        far_i.pulse(ev(9));
        chk("wakeup", STA, 8'h02, 8'h02);
        far_i.pulse(ev(14));
        chk("done start", STA, 8'h03, 8'h00);
        far_i.pulse(ev(13));
        chk("done end", STA, 8'h01, 8'h01);
        far_i.level(ev(17) | ev(10));
        chk("wakeup tx", STA, 8'h02, 8'h02);
        far_i.level(ev(17));
        chk("wakeup off", STA, 8'h02, 8'h00);
        foreach (err_ev[i])
        begin
            far_i.pulse(err_ev[i]);
            chk("cause", ERR, 8'hff, err_bit[i]);
            chk("fault", STA, 8'h04, 8'h04);
            wr(ERR, 8'hff);
            chk("sticky", ERR, 8'hff, err_bit[i]);
            clr();
            chk("cleared", ERR, 8'hff, 8'h00);
            chk("fault off", STA, 8'h04, 8'h00);
        end
        far_i.pulse(ev(11));
        chk("int", STA, 8'h08, 8'h08);
        wr(CTL, 8'h08);
        chk("int off", STA, 8'h08, 8'h00);
        $display("test flags done");
        far_i.pulse(ev(12));
        chk("request", STA, 8'h10, 8'h10);
        far_i.pulse(ev(0));
        chk("late ack", ERR, 8'h04, 8'h04);
        clr();
        far_i.pulse(ev(12));
        wr(CTL, 8'h10);
        // The pulse stands in the cycle after the commit edge
        wt(1);
        same("data ack", 8'h01, {7'h0, cmd.data_ack});
        far_i.pulse(ev(0));
        chk("prompt ack", ERR, 8'h04, 8'h00);
        far_i.pulse(ev(14));
        far_i.pulse(ev(15));
        chk("abort", STA, 8'h20, 8'h20);
        far_i.pulse(ev(13));
        far_i.pulse(ev(15));
        chk("abort off", STA, 8'h20, 8'h00);
        wr(CTL, 8'h80);
        chk("halt abort", STA, 8'h20, 8'h20);
        same("halted", 8'h01, {7'h0, cmd.halted});
        far_i.pulse(ev(11));
        chk("ignored", STA, 8'h08, 8'h00);
        far_i.pulse(ev(15));
        // Release lands at the edge that samples the break
        wt(1);
        same("resumed", 8'h00, {7'h0, cmd.halted});
        $display("test slave done");
        far_i.pulse(ev(14));
        wt(45);
        chk("frame long", ERR, 8'h04, 8'h04);
        far_i.pulse(ev(13));
        clr();
        far_i.level(ev(17) | ev(2));
        wt(25);
        chk("no data", ERR, 8'h04, 8'h04);
        far_i.level(ev(17));
        clr();
        wr(MOD, 8'h01);
        chk("mode", MOD, 8'hff, 8'h01);
        far_i.level(ev(17) | ev(2));
        wt(25);
        chk("no answer", ERR, 8'h04, 8'h04);
        $display("test timeouts done");
        final_report();
    end
endmodule : tb
